/* File: pmca_top.sv */
// Macrocell array with product-term AND array and Wishbone configuration
// Behaviour
// R1 - Power-up clears every macrocell register in time
// R2 - Registered outputs read high after power-up
// R3 - Registered pin drives inverse of register
// R4 - Outside meets setup before first clock
// R5 - Outside keeps clock still during power-up
// R6 - Preload forces each register high or low
// R7 - Secured device refuses verify and preload
// R8 - Sixty-four bit signature always readable
// R9 - Outside programs security fuse last
// R10 - Undriven inputs and pins read high
// R11 - Each cell: registered, comb I/O, output, input
// R12 - One of three global architecture modes
// R13 - Registered mode keeps clock, OE pins dedicated
// R14 - Complex mode feeds clock, OE through outer columns
// R15 - Simple mode adjacent feedback, inner cells fixed
// R16 - Register takes eight-term sum, OE from pin
// R17 - Combinatorial cell: one OE term, seven terms
// R18 - Input cell keeps driver disabled
`timescale 1ns/10ps
`default_nettype none

module pmca_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [8:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] in_i,
    input wire logic [7:0] in_drv_i,
    input wire logic pclk_i,
    input wire logic oe_n_i,
    input wire logic [7:0] io_in_i,
    input wire logic [7:0] io_drv_i,
    output logic [7:0] io_out_o,
    output logic [7:0] io_oe_n_o
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Pin level as the array sees it: weak pull-up when undriven
    function automatic logic [7:0] pull_up(input logic [7:0] v, input logic [7:0] d);
        pull_up = v | ~d; // [R10]
    endfunction

    // One product term: every selected literal must be true
    function automatic logic pterm(input logic [31:0] m, input logic [15:0] c);
        logic [31:0] lit;
        lit = '0;
        for (int k = 0; k < 16; k++) begin
            lit[2*k] = c[k];
            lit[2*k+1] = ~c[k];
        end
        pterm = &(~m | lit);
    endfunction

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        merge = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                merge[8*b +: 8] = n[8*b +: 8];
            end
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0] term_q [pmca_pkg::N_TERM]; // AND array fuse map
    pmca_pkg::pmca_ctrl_t ctrl_q;  // Mode and security fuse
    logic [15:0] mccfg_q;          // Two mode bits per cell
    logic [63:0] sig_q;            // User signature
    logic [7:0] mc_q;              // Macrocell registers
    logic [7:0] mc_d;
    logic [7:0] out_q;             // Pin output values
    logic [7:0] out_d;
    logic [7:0] oe_n_q;            // Pin enables, low drives
    logic [7:0] oe_n_d;
    logic [7:0] por_cnt_q;         // Power-up reset countdown
    logic pclk_q;                  // Last clock pin level
    logic ack_q;
    logic [31:0] dat_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wr = req & wb_we_i;
    wire rd = req & ~wb_we_i;
    wire arr_hit = wb_adr_i[pmca_pkg::ARRAY_BIT];
    wire [5:0] widx = wb_adr_i[7:2];
    wire hit_ctrl = ~arr_hit && wb_adr_i == pmca_pkg::ADR_CTRL;
    wire hit_cfg = ~arr_hit && wb_adr_i == pmca_pkg::ADR_MCCFG;
    wire hit_pre = ~arr_hit && wb_adr_i == pmca_pkg::ADR_PRELOAD;
    wire hit_st = ~arr_hit && wb_adr_i == pmca_pkg::ADR_STATUS;
    wire hit_s0 = ~arr_hit && wb_adr_i == pmca_pkg::ADR_SIG0;
    wire hit_s1 = ~arr_hit && wb_adr_i == pmca_pkg::ADR_SIG1;
    wire por_busy = por_cnt_q != 8'h00;
    wire secure = ctrl_q.secure;
    wire pclk_rise = pclk_i & ~pclk_q;
    wire [31:0] ctrl_new = merge({29'h0, ctrl_q}, wb_dat_i, wb_sel_i);
    // Preload refused while secured or during power-up
    wire pre_ok = wr & hit_pre & ~secure & ~por_busy; // [R7]
    wire [7:0] pre_val = wb_dat_i[7:0];
    wire [7:0] pre_sel = wb_dat_i[pmca_pkg::PRE_SEL_LSB +: 8];

    // Status word
    wire [31:0] status_w = {6'h00, secure, por_busy, oe_n_q, out_q, mc_q};
    // Read mux; a secured array reads back as zero
    wire [31:0] rdata =
        arr_hit ? (secure ? 32'h0000_0000 : term_q[widx]) : // [R7]
        hit_ctrl ? {29'h0, ctrl_q} :
        hit_cfg ? {16'h0000, mccfg_q} :
        hit_st ? status_w :
        hit_s0 ? sig_q[31:0] : // [R8]
        hit_s1 ? sig_q[63:32] :
        32'h0000_0000;

    // ------------------------------------------------------------
    // Array inputs and cell modes
    // ------------------------------------------------------------
    wire [7:0] in_lvl = pull_up(in_i, in_drv_i);
    wire [7:0] io_lvl = pull_up(io_in_i, io_drv_i);
    pmca_pkg::pmca_mc_mode_t eff [pmca_pkg::N_MC]; // Mode after arch limits
    logic [7:0] fb;        // Feedback columns
    logic [7:0] is_reg;    // Cells that are registered
    logic [pmca_pkg::N_TERM-1:0] pt;
    logic [7:0] sum8;
    logic [7:0] sum7;
    logic [7:0] oe_pt;

    // Effective mode and feedback per cell
    always_comb begin
        fb = io_lvl;
        is_reg = '0;
        for (int i = 0; i < pmca_pkg::N_MC; i++) begin
            eff[i] = pmca_pkg::pmca_mc_mode_t'(mccfg_q[2*i +: 2]); // [R11]
            unique case (ctrl_q.arch) // [R12]
                pmca_pkg::PMCA_ARCH_REG: begin
                    // Clock and OE pins never reach the array here
                    if (eff[i] == pmca_pkg::PMCA_MC_REGOUT) begin
                        fb[i] = mc_q[i]; // [R13]
                    end
                end
                pmca_pkg::PMCA_ARCH_CPLX: begin
                    // No registers; outer cells are outputs only
                    if (eff[i] == pmca_pkg::PMCA_MC_REGOUT ||
                        (eff[i] == pmca_pkg::PMCA_MC_INPUT &&
                         (i == pmca_pkg::OUTER_LO || i == pmca_pkg::OUTER_HI))) begin
                        eff[i] = pmca_pkg::PMCA_MC_COMBIO;
                    end
                    if (i == pmca_pkg::OUTER_LO) begin
                        fb[i] = oe_n_i; // [R14]
                    end else if (i == pmca_pkg::OUTER_HI) begin
                        fb[i] = pclk_i; // [R14]
                    end
                end
                default: begin
                    // Simple: no OE terms, inner cells fixed outputs
                    if (i == pmca_pkg::INNER_LO || i == pmca_pkg::INNER_HI) begin
                        eff[i] = pmca_pkg::PMCA_MC_COMBOUT; // [R15]
                        fb[i] = 1'b1;
                    end else begin
                        if (eff[i] != pmca_pkg::PMCA_MC_INPUT) begin
                            eff[i] = pmca_pkg::PMCA_MC_COMBOUT;
                        end
                        fb[i] = (i < pmca_pkg::INNER_HI) ? io_lvl[i+1] : io_lvl[i-1]; // [R15]
                    end
                end
            endcase
            is_reg[i] = eff[i] == pmca_pkg::PMCA_MC_REGOUT;
        end
    end

    // Product terms and sums
    always_comb begin
        for (int t = 0; t < pmca_pkg::N_TERM; t++) begin
            pt[t] = pterm(term_q[t], {fb, in_lvl});
        end
        for (int i = 0; i < pmca_pkg::N_MC; i++) begin
            sum8[i] = |pt[8*i +: 8];
            sum7[i] = |pt[8*i+1 +: 7];
            oe_pt[i] = pt[8*i];
        end
    end

    // ------------------------------------------------------------
    // Next register and pin values
    // ------------------------------------------------------------
    always_comb begin
        mc_d = mc_q;
        out_d = out_q;
        oe_n_d = oe_n_q;
        for (int i = 0; i < pmca_pkg::N_MC; i++) begin
            // Register follows the common clock, never during power-up
            if (pclk_rise && !por_busy && is_reg[i]) begin
                mc_d[i] = sum8[i]; // [R16]
            end
            unique case (eff[i])
                pmca_pkg::PMCA_MC_REGOUT: begin
                    out_d[i] = ~mc_q[i]; // [R3] [R2]
                    oe_n_d[i] = oe_n_i; // [R16]
                end
                pmca_pkg::PMCA_MC_COMBIO: begin
                    out_d[i] = sum7[i]; // [R17]
                    oe_n_d[i] = ~oe_pt[i];
                end
                pmca_pkg::PMCA_MC_COMBOUT: begin
                    // Registered and complex modes still spend one term on enable
                    out_d[i] = (ctrl_q.arch == pmca_pkg::PMCA_ARCH_SIMPLE) ? sum8[i] : sum7[i];
                    oe_n_d[i] = (ctrl_q.arch == pmca_pkg::PMCA_ARCH_SIMPLE) ? 1'b0 : ~oe_pt[i];
                end
                pmca_pkg::PMCA_MC_INPUT: begin
                    out_d[i] = 1'b1;
                    oe_n_d[i] = 1'b1; // [R18]
                end
            endcase
        end
        // Preload wins over a clock edge in the same cycle
        if (pre_ok) begin
            mc_d = (mc_d & ~pre_sel) | (pre_val & pre_sel); // [R6]
        end
    end

    // ------------------------------------------------------------
    // Macrocells and power-up reset
    // ------------------------------------------------------------
    // Reset stands for the supply crossing powerup_reset_threshold
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mc_q <= 8'h00; // [R1]
            out_q <= 8'hff;
            oe_n_q <= 8'hff;
            por_cnt_q <= 8'(pmca_pkg::POR_CYCLES);
            pclk_q <= 1'b0;
        end else begin
            mc_q <= mc_d;
            out_q <= out_d;
            oe_n_q <= oe_n_d;
            pclk_q <= pclk_i;
            if (por_busy) begin
                por_cnt_q <= por_cnt_q - 8'h01; // [R1]
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Fuse map has no reset: it models nonvolatile storage
    always_ff @(posedge clk_i) begin
        if (wr && arr_hit) begin
            term_q[widx] <= merge(term_q[widx], wb_dat_i, wb_sel_i);
        end
    end

    // Mode, cell configuration, fuse and signature
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= pmca_pkg::CTRL_RESET;
            mccfg_q <= pmca_pkg::MCCFG_RESET;
            sig_q <= 64'h0;
        end else if (wr) begin
            if (hit_ctrl && ctrl_new[1:0] != 2'h3) begin
                ctrl_q.arch <= pmca_pkg::pmca_arch_t'(ctrl_new[1:0]);
            end
            if (hit_ctrl && ctrl_new[pmca_pkg::CTRL_SECURE_BIT]) begin
                ctrl_q.secure <= 1'b1; // Takes effect on the next access
            end
            if (hit_cfg) begin
                mccfg_q <= 16'(merge({16'h0000, mccfg_q}, wb_dat_i, wb_sel_i));
            end
            if (hit_s0) begin
                sig_q[31:0] <= merge(sig_q[31:0], wb_dat_i, wb_sel_i); // [R8]
            end
            if (hit_s1) begin
                sig_q[63:32] <= merge(sig_q[63:32], wb_dat_i, wb_sel_i);
            end
        end
    end

    // ------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------
    // One wait state; unmapped reads give zero, writes drop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (rd) begin
                dat_q <= rdata;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign io_out_o = out_q;
    assign io_oe_n_o = oe_n_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_por_clear: assert property ( // [R1]
        por_busy |-> mc_q == 8'h00)
        else $error("register not clear during power-up");

    chk_por_high: assert property ( // [R2]
        (por_busy && $past(por_busy)) |=> ((io_out_o & $past(is_reg)) == $past(is_reg)))
        else $error("registered pin not high after power-up");

    chk_reg_invert: assert property ( // [R3]
        1'b1 |=> (((io_out_o ^ ~$past(mc_q)) & $past(is_reg)) == 8'h00))
        else $error("registered pin not inverse of register");

    chk_preload_set: assert property ( // [R6]
        pre_ok |=> ((mc_q ^ $past(pre_val)) & $past(pre_sel)) == 8'h00)
        else $error("preload value not loaded");

    chk_secure_verify: assert property ( // [R7]
        (rd && arr_hit && secure) |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
        else $error("secured array read back");

    chk_secure_preload: assert property ( // [R7]
        (wr && hit_pre && secure && !pclk_rise) |=> $stable(mc_q))
        else $error("preload taken while secured");

    chk_sig_read: assert property ( // [R8]
        (rd && hit_s1) |=> wb_dat_o == $past(sig_q[63:32]))
        else $error("signature not readable");

    chk_pull_high: assert property ( // [R10]
        ((in_lvl | in_drv_i) & (io_lvl | io_drv_i)) == 8'hff)
        else $error("undriven input not seen high");

    chk_input_off: assert property ( // [R18]
        is_reg == 8'h00 && eff[1] == pmca_pkg::PMCA_MC_INPUT |=> io_oe_n_o[1])
        else $error("input cell drives its pin");

    chk_reg_clock: assert property ( // [R16]
        (pclk_rise && !por_busy && !pre_ok && is_reg[2]) |=> mc_q[2] == $past(sum8[2]) ##1
        io_out_o[2] == ~$past(mc_q[2]))
        else $error("register missed clock edge");

    chk_cplx_cols: assert property ( // [R14]
        ctrl_q.arch == pmca_pkg::PMCA_ARCH_CPLX |-> fb[7] == pclk_i && fb[0] == oe_n_i)
        else $error("clock or oe pin not on outer column");

    chk_simple_inner: assert property ( // [R15]
        ctrl_q.arch == pmca_pkg::PMCA_ARCH_SIMPLE [*2] |=> io_oe_n_o[4:3] == 2'b00)
        else $error("inner cell not enabled in simple mode");

endmodule

`default_nettype wire

/* File: pmca_pkg.sv */
// Constants, types and register map of the macrocell array
package pmca_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int unsigned N_MC = 8;    // Macrocells
    localparam int unsigned N_PT = 8;    // Product terms per macrocell
    localparam int unsigned N_IN = 8;    // Dedicated inputs
    localparam int unsigned N_COL = 16;  // Array columns: inputs then feedback
    localparam int unsigned N_LIT = 32;  // True and complement of each column
    localparam int unsigned N_TERM = 64; // Product terms in the array
    localparam int unsigned OUTER_LO = 0; // Cell whose column takes the OE pin
    localparam int unsigned OUTER_HI = 7; // Cell whose column takes the clock pin
    localparam int unsigned INNER_LO = 3; // Inner cells, fixed outputs in simple mode
    localparam int unsigned INNER_HI = 4;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [8:0] ADR_CTRL = 9'h000;
    localparam logic [8:0] ADR_MCCFG = 9'h004;
    localparam logic [8:0] ADR_PRELOAD = 9'h008;
    localparam logic [8:0] ADR_STATUS = 9'h00c;
    localparam logic [8:0] ADR_SIG0 = 9'h010;
    localparam logic [8:0] ADR_SIG1 = 9'h014;
    localparam int unsigned ARRAY_BIT = 8; // Address bit that selects the array

    // Field positions
    localparam int unsigned CTRL_SECURE_BIT = 2;
    localparam int unsigned PRE_SEL_LSB = 8;
    localparam int unsigned ST_OUT_LSB = 8;
    localparam int unsigned ST_OE_LSB = 16;
    localparam int unsigned ST_POR_BIT = 24;
    localparam int unsigned ST_SEC_BIT = 25;

    // ------------------------------------------------------------
    // Modes and control
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PMCA_ARCH_REG,
        PMCA_ARCH_CPLX,
        PMCA_ARCH_SIMPLE
    } pmca_arch_t;

    typedef enum logic [1:0] {
        PMCA_MC_REGOUT,
        PMCA_MC_COMBIO,
        PMCA_MC_COMBOUT,
        PMCA_MC_INPUT
    } pmca_mc_mode_t;

    typedef struct packed {
        logic secure;      // Security fuse, set only
        pmca_arch_t arch;  // Global architecture mode
    } pmca_ctrl_t;

    localparam pmca_ctrl_t CTRL_RESET = '{secure: 1'b0, arch: PMCA_ARCH_REG};
    localparam logic [15:0] MCCFG_RESET = 16'hffff; // All cells inputs

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned POWERUP_RESET_TIME_NS = 1000;
    // Longest time, so rounded down
    localparam int unsigned POR_CYCLES = POWERUP_RESET_TIME_NS / CLK_PERIOD_NS;

endpackage

/* File: pmca_board.sv */
// Board model that drives the macrocell array's input and I/O pins
`timescale 1ns/10ps
`default_nettype none

module pmca_board (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] in_v_i,
    input wire logic [7:0] in_d_i,
    input wire logic [7:0] io_v_i,
    input wire logic [7:0] io_d_i,
    input wire logic pclk_req_i,
    input wire logic oe_req_i,
    input wire logic [7:0] io_out_i,
    input wire logic [7:0] io_oe_n_i,
    output logic [7:0] in_o,
    output logic [7:0] in_drv_o,
    output logic [7:0] io_in_o,
    output logic [7:0] io_drv_o,
    output logic pclk_o,
    output logic oe_n_o
);
    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    int unsigned por_q = 0; // Cycles since reset release
    logic [7:0] in_q = 8'h00; // Input pin levels
    logic pclk_q = 1'b0; // Pin clock, still outside use
    logic oe_q = 1'b0; // Enable pin level

    // Undriven inputs toggle, so only the drive flag can make them read high
    always @(posedge clk_i) begin
        if (rst_i) begin
            por_q <= 0;
            in_q <= 8'h00;
            pclk_q <= 1'b0;
        end else begin
            if (por_q < pmca_pkg::POR_CYCLES) begin
                por_q <= por_q + 1;
            end
            in_q <= (in_v_i & in_d_i) | (~in_q & ~in_d_i);
            pclk_q <= pclk_req_i && (por_q == pmca_pkg::POR_CYCLES);
        end
        oe_q <= oe_req_i;
    end

    assign in_o = in_q;
    assign in_drv_o = in_d_i;
    assign pclk_o = pclk_q;
    assign oe_n_o = oe_q;
    // Wire level: block driver first, then board driver, else pulled high
    assign io_drv_o = ~io_oe_n_i | io_d_i;
    assign io_in_o = (~io_oe_n_i & io_out_i) | (io_oe_n_i & ((io_d_i & io_v_i) | ~io_d_i));
endmodule

`default_nettype wire

/* File: testbench.sv */
// Self-checking testbench of the macrocell array
`timescale 1ns/10ps
`default_nettype none

module testbench;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [8:0] adr = 9'h000;
    logic [3:0] sel = 4'hf;
    logic [31:0] dat = 32'h0;
    logic [31:0] rd;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [7:0] in_v = 8'h00;
    logic [7:0] in_d = 8'hff;
    logic [7:0] io_v = 8'h00;
    logic [7:0] io_d = 8'h00;
    logic pclk_req = 1'b0;
    logic oe_req = 1'b0;
    logic [7:0] in_i, in_drv_i, io_in_i, io_drv_i, io_out_o, io_oe_n_o;
    logic pclk_i, oe_n_i;
    logic [7:0] exp_q, v, s;
    logic [31:0] w;
    logic [31:0] sg [2];
    int errors = 0;
    int compares = 0;
    integer seed = 32'h620c;

    pmca_top pmca_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .in_i(in_i), .in_drv_i(in_drv_i), .pclk_i(pclk_i),
        .oe_n_i(oe_n_i), .io_in_i(io_in_i), .io_drv_i(io_drv_i), .io_out_o(io_out_o),
        .io_oe_n_o(io_oe_n_o));

    pmca_board pmca_board_i (.clk_i(clk_i), .rst_i(rst_i), .in_v_i(in_v), .in_d_i(in_d),
        .io_v_i(io_v), .io_d_i(io_d), .pclk_req_i(pclk_req), .oe_req_i(oe_req),
        .io_out_i(io_out_o), .io_oe_n_i(io_oe_n_o), .in_o(in_i), .in_drv_o(in_drv_i),
        .io_in_o(io_in_i), .io_drv_o(io_drv_i), .pclk_o(pclk_i), .oe_n_o(oe_n_i));

    // 125 MHz clock
    initial begin
        forever #4 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Tasks and expectations
    // ----------------------------------------
    task automatic conclude();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            errors++;
            $display("Error bus ack expected 1 seen timeout");
            conclude();
        end
    endtask

    task automatic term(input int t, input logic [31:0] d);
        bus(1'b1, 9'h100 + 9'(4 * t), d);
    endtask

    // Undriven inputs read as one
    function automatic logic [7:0] seen(input logic [7:0] val, input logic [7:0] drv);
        return val | ~drv;
    endfunction

    // Register content after a preload
    function automatic logic [7:0] pre(input logic [7:0] q, input logic [7:0] val,
                                       input logic [7:0] m);
        return (q & ~m) | (val & m);
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b1, pmca_pkg::ADR_PRELOAD, 32'h0000ffff);
        bus(1'b1, pmca_pkg::ADR_MCCFG, 32'h0);
        bus(1'b0, pmca_pkg::ADR_STATUS, 32'h0);
        chk("power-up status", 32'h0100ff00, rd);
        for (int n = 0; n < 100 && rd[24] !== 1'b0; n++) bus(1'b0, pmca_pkg::ADR_STATUS, 32'h0);
        chk("power-up end", 32'h0, {31'h0, rd[24]});
        if (rd[24] !== 1'b0) conclude();
        $display("test power-up done");

        // Each register follows one input column
        for (int t = 0; t < 64; t++) term(t, 32'h3);
        for (int i = 0; i < 8; i++) term(8 * i + 1, 32'h1 << (2 * i));
        for (int k = 0; k < 4; k++) begin
            in_v <= 8'($random(seed));
            in_d <= (k == 0) ? 8'h00 : 8'($random(seed));
            repeat (2) @(posedge clk_i);
            pclk_req <= 1'b1;
            repeat (6) @(posedge clk_i);
            pclk_req <= 1'b0;
            exp_q = seen(in_v, in_d);
            bus(1'b0, pmca_pkg::ADR_STATUS, 32'h0);
            chk("registers", {24'h0, exp_q}, {24'h0, rd[7:0]});
            chk("registered pins", {24'h0, ~exp_q}, {24'h0, io_out_o});
            chk("registered enables", 32'h0, {24'h0, io_oe_n_o});
        end
        oe_req <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("pin disable", 32'hff, {24'h0, io_oe_n_o});
        for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? 8'($random(seed)) : ((k == 1) ? 8'h00 : 8'hff);
            s = (k == 0) ? 8'($random(seed)) : 8'hff;
            bus(1'b1, pmca_pkg::ADR_PRELOAD, {16'h0, s, v});
            exp_q = pre(exp_q, v, s);
            bus(1'b0, pmca_pkg::ADR_STATUS, 32'h0);
            chk("preload", {24'h0, exp_q}, {24'h0, rd[7:0]});
        end
        oe_req <= 1'b0;
        $display("test registered done");

        // Even cells enabled by their term, odd ones not
        for (int i = 0; i < 8; i++) term(8 * i, (i % 2) ? 32'h3 : 32'h0);
        bus(1'b1, pmca_pkg::ADR_MCCFG, 32'haaaa);
        repeat (3) @(posedge clk_i);
        chk("comb enables", 32'haa, {24'h0, io_oe_n_o});
        chk("comb outputs", {24'h0, seen(in_v, in_d)}, {24'h0, io_out_o});
        bus(1'b1, pmca_pkg::ADR_MCCFG, 32'he4e4);
        repeat (3) @(posedge clk_i);
        chk("mixed cells", 32'haa, {24'h0, io_oe_n_o});
        bus(1'b1, pmca_pkg::ADR_MCCFG, 32'hffff);
        repeat (3) @(posedge clk_i);
        chk("input cells", 32'hff, {24'h0, io_oe_n_o});

        // Cell one's enable term watches the enable pin column
        term(8, 32'h1 << 16);
        bus(1'b1, pmca_pkg::ADR_MCCFG, 32'haaaa);
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, pmca_pkg::ADR_CTRL, 32'(m));
            oe_req <= 1'b0;
            repeat (3) @(posedge clk_i);
            v = io_oe_n_o;
            oe_req <= 1'b1;
            repeat (3) @(posedge clk_i);
            if (m == 0) begin
                chk("dedicated enable pin", {24'h0, v}, {24'h0, io_oe_n_o});
            end else begin
                chk("enable pin low", 32'haa, {24'h0, v});
                chk("enable pin high", 32'ha8, {24'h0, io_oe_n_o});
            end
        end
        oe_req <= 1'b0;
        bus(1'b1, pmca_pkg::ADR_CTRL, 32'h2);
        bus(1'b1, pmca_pkg::ADR_MCCFG, 32'hffff);
        repeat (3) @(posedge clk_i);
        chk("simple inner cells", 32'he7, {24'h0, io_oe_n_o});
        bus(1'b1, pmca_pkg::ADR_MCCFG, 32'haaaa);
        repeat (3) @(posedge clk_i);
        chk("simple outputs", 32'h0, {24'h0, io_oe_n_o});
        chk("simple sums", {24'h0, 8'h57 | (seen(in_v, in_d) & 8'ha8)}, {24'h0, io_out_o});
        $display("test modes done");

        // Security fuse against verify, preload and signature
        w = $random(seed);
        term(5, w);
        bus(1'b0, 9'h114, 32'h0);
        chk("array verify", w, rd);
        for (int k = 0; k < 2; k++) begin
            sg[k] = $random(seed);
            bus(1'b1, pmca_pkg::ADR_SIG0 + 9'(4 * k), sg[k]);
        end
        bus(1'b0, pmca_pkg::ADR_STATUS, 32'h0);
        s = rd[7:0];
        bus(1'b1, pmca_pkg::ADR_CTRL, 32'h4);
        bus(1'b0, 9'h114, 32'h0);
        chk("array secured", 32'h0, rd);
        bus(1'b1, pmca_pkg::ADR_PRELOAD, {16'h0, 8'hff, ~s});
        bus(1'b0, pmca_pkg::ADR_STATUS, 32'h0);
        chk("secured preload", {24'h0, s}, {24'h0, rd[7:0]});
        chk("secure flag", 32'h1, {31'h0, rd[25]});
        for (int k = 0; k < 2; k++) begin
            bus(1'b0, pmca_pkg::ADR_SIG0 + 9'(4 * k), 32'h0);
            chk("signature", sg[k], rd);
        end
        bus(1'b1, 9'h018, 32'($random(seed)));
        bus(1'b0, 9'h018, 32'h0);
        chk("unmapped read", 32'h0, rd);
        $display("test security done");
        conclude();
    end
endmodule

`default_nettype wire
